// ---- core/txb_pkg.sv ----
package txb_pkg;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned RAM_DEPTH = 32;
  localparam int unsigned CNT_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
  localparam logic [ADDR_W-1:0] FRAME_LAST_RESET = 5'h13;

  typedef enum logic [2:0] {
    TXB_EMPTY      = 3'b000,
    TXB_READY      = 3'b001,
    TXB_TX_PROG    = 3'b010,
    TXB_ABORT_PROG = 3'b011,
    TXB_TX_OK      = 3'b100,
    TXB_ABORTED    = 3'b101,
    TXB_TX_FAILED  = 3'b110
  } txb_state_t;

  localparam txb_state_t STATE_RESET = TXB_EMPTY;

  typedef enum logic [1:0] {
    PC_IDLE = 2'b00,
    PC_XMIT = 2'b01
  } pc_state_t;

  localparam pc_state_t PC_RESET = PC_IDLE;

endpackage

// ---- core/txb_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface txb_link_if;
  import txb_pkg::*;

  logic available;
  logic hw_lock;
  logic hw_unlock_done;
  logic hw_unlock_error;
  logic hw_unlock_arbl;
  logic hw_unlock_failed;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;
  logic [CNT_W-1:0] retx_count;

  modport buffer_end (
    output available,
    output rd_data,
    output retx_count,
    input hw_lock,
    input hw_unlock_done,
    input hw_unlock_error,
    input hw_unlock_arbl,
    input hw_unlock_failed,
    input rd_addr
  );

  modport control_end (
    input available,
    input rd_data,
    input retx_count,
    output hw_lock,
    output hw_unlock_done,
    output hw_unlock_error,
    output hw_unlock_arbl,
    output hw_unlock_failed,
    output rd_addr
  );

endinterface

`default_nettype wire

// ---- core/txb_frame_ram.sv ----
`timescale 1ns/1ps
`default_nettype none

module txb_frame_ram
  import txb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [WORD_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [WORD_W-1:0] rd_data_o
);

  logic [WORD_W-1:0] mem [RAM_DEPTH];

  // Port A write, port B registered read
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

`default_nettype wire

// ---- core/txb_device.sv ----
// Operation
// - Software commands by register, hardware by controller
// - Ready command valid in Empty/OK/Aborted/Failed
// - Empty command valid in OK/Aborted/Failed only
// - Abort valid in Ready/TX/Abort in progress
// - Controller locks only a Ready buffer
// - Unlock-done moves buffer to TX OK
// - Unlock-error issued on error frame
// - Unlock-arbitration-lost issued on lost arbitration
// - Unlock-failed issued at retransmit threshold
// - Invalid software command leaves state unchanged
// - Controller never issues an invalid hardware command
// - Lock plus abort in Ready: Abort in progress
// - Abort with done/failed: TX OK/TX failed
// - Dual-port RAM, software write-only
// - Unlocked buffer accepts software writes
// - Locked in Ready/transmitting, writes discarded
// - Available while state is Ready
// - Abort drops availability in same cycle
// - Abort in Ready registers next state next cycle
// - Ready command to Ready, lock to TX
// - Error/arb lost: back to Ready, count up; with abort: Aborted
// - Abort in progress: error to Aborted, done OK
`timescale 1ns/1ps
`default_nettype none

module txb_device
  import txb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  txb_link_if.buffer_end link,
  input wire logic cmd_ready_i,
  input wire logic cmd_empty_i,
  input wire logic cmd_abort_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [WORD_W-1:0] wr_data_i,
  output logic [2:0] state_o,
  output logic locked_o,
  output logic [CNT_W-1:0] retx_count_o
);

  txb_state_t state_reg;
  txb_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic locked_reg;
  logic locked_next;
  logic ram_we;
  logic hw_stop;
  // Gated software commands
  logic sw_ready;
  logic sw_empty;
  logic sw_abort;

  function automatic logic is_locked(input txb_state_t s);
    is_locked = (s == TXB_READY) || (s == TXB_TX_PROG) || (s == TXB_ABORT_PROG);
  endfunction

  function automatic logic is_done_state(input txb_state_t s);
    is_done_state = (s == TXB_TX_OK) || (s == TXB_ABORTED) || (s == TXB_TX_FAILED);
  endfunction

  // Valid-state decoding for software commands
  function automatic logic accepts_ready(input txb_state_t s);
    accepts_ready = (s == TXB_EMPTY) || is_done_state(s);
  endfunction

  function automatic logic accepts_empty(input txb_state_t s);
    accepts_empty = is_done_state(s);
  endfunction

  function automatic logic accepts_abort(input txb_state_t s);
    accepts_abort = is_locked(s);
  endfunction

  // Error or lost arbitration both end an attempt
  assign hw_stop = link.hw_unlock_error || link.hw_unlock_arbl;

  assign sw_ready = cmd_ready_i && accepts_ready(state_reg);
  assign sw_empty = cmd_empty_i && accepts_empty(state_reg);
  assign sw_abort = cmd_abort_i && accepts_abort(state_reg);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      TXB_EMPTY: begin
        if (sw_ready) begin
          state_next = TXB_READY;
          cnt_next = CNT_RESET;
        end
      end
      TXB_READY: begin
        if (link.hw_lock && sw_abort) begin
          state_next = TXB_ABORT_PROG;
        end else if (link.hw_lock) begin
          state_next = TXB_TX_PROG;
        end else if (sw_abort) begin
          state_next = TXB_ABORTED;
        end
      end
      TXB_TX_PROG: begin
        if (link.hw_unlock_done) begin
          state_next = TXB_TX_OK;
        end else if (link.hw_unlock_failed) begin
          state_next = TXB_TX_FAILED;
        end else if (hw_stop) begin
          if (sw_abort) begin
            state_next = TXB_ABORTED;
          end else begin
            state_next = TXB_READY;
            if (cnt_reg != CNT_MAX) begin
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end else if (sw_abort) begin
          state_next = TXB_ABORT_PROG;
        end
      end
      TXB_ABORT_PROG: begin
        if (link.hw_unlock_done) begin
          state_next = TXB_TX_OK;
        end else if (link.hw_unlock_failed) begin
          state_next = TXB_TX_FAILED;
        end else if (hw_stop) begin
          state_next = TXB_ABORTED;
        end
      end
      TXB_TX_OK,
      TXB_ABORTED,
      TXB_TX_FAILED: begin
        if (sw_ready) begin
          state_next = TXB_READY;
          cnt_next = CNT_RESET;
        end else if (sw_empty) begin
          state_next = TXB_EMPTY;
          cnt_next = CNT_RESET;
        end
      end
      default: begin
        state_next = STATE_RESET;
        cnt_next = CNT_RESET;
      end
    endcase
    locked_next = is_locked(state_next);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= STATE_RESET;
      cnt_reg <= CNT_RESET;
      locked_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      locked_reg <= locked_next;
    end
  end

  assign ram_we = wr_en_i && !is_locked(state_reg);

  // Software port A, controller port B
  txb_frame_ram u_ram (
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .wr_en_i(ram_we),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .rd_addr_i(link.rd_addr),
    .rd_data_o(link.rd_data)
  );

  assign link.available = (state_reg == TXB_READY) && !cmd_abort_i;
  assign link.retx_count = cnt_reg;

  assign state_o = state_reg;
  assign locked_o = locked_reg;
  assign retx_count_o = cnt_reg;

endmodule

`default_nettype wire

// ---- core/txb_host.sv ----
// Controller end of the buffer link
`timescale 1ns/1ps
`default_nettype none

module txb_host
  import txb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  txb_link_if.control_end link,
  input wire logic start_i,
  input wire logic [ADDR_W-1:0] frame_last_i,
  input wire logic [CNT_W-1:0] retx_limit_i,
  input wire logic bus_done_i,
  input wire logic bus_err_i,
  input wire logic bus_arbl_i,
  output logic busy_o,
  output logic word_valid_o,
  output logic [WORD_W-1:0] word_o
);

  pc_state_t st_reg;
  pc_state_t st_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic valid_reg;
  logic lock;
  logic outcome;
  logic at_limit;

  // Lock only on a live Ready buffer
  assign lock = (st_reg == PC_IDLE) && start_i && link.available;
  assign outcome = (st_reg == PC_XMIT) && (bus_done_i || bus_err_i || bus_arbl_i);
  assign at_limit = link.retx_count >= retx_limit_i;

  assign link.hw_lock = lock;
  assign link.hw_unlock_done = outcome && bus_done_i;
  assign link.hw_unlock_error = outcome && !bus_done_i && bus_err_i && !at_limit;
  assign link.hw_unlock_arbl = outcome && !bus_done_i && !bus_err_i && !at_limit;
  assign link.hw_unlock_failed = outcome && !bus_done_i && at_limit;
  assign link.rd_addr = addr_reg;

  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    rd_pend_next = 1'b0;
    case (st_reg)
      PC_IDLE: begin
        if (lock) begin
          st_next = PC_XMIT;
          addr_next = ADDR_RESET;
        end
      end
      PC_XMIT: begin
        if (outcome) begin
          st_next = PC_IDLE;
        end else if (addr_reg <= frame_last_i) begin
          rd_pend_next = 1'b1;
          addr_next = addr_reg + 5'h01;
        end
      end
      default: begin
        st_next = PC_RESET;
        addr_next = ADDR_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= PC_RESET;
      addr_reg <= ADDR_RESET;
      rd_pend_reg <= 1'b0;
      valid_reg <= 1'b0;
      busy_o <= 1'b0;
      word_o <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      rd_pend_reg <= rd_pend_next;
      valid_reg <= rd_pend_reg;
      busy_o <= (st_next == PC_XMIT);
      if (rd_pend_reg) begin
        word_o <= link.rd_data;
      end
    end
  end

  assign word_valid_o = valid_reg;

endmodule

`default_nettype wire

// ---- sim/txb_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module txb_sva
  import txb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic cmd_abort_i,
  input wire logic [2:0] state_o,
  input wire logic available,
  input wire logic hw_lock,
  input wire logic hw_unlock_done,
  input wire logic hw_unlock_error,
  input wire logic hw_unlock_arbl,
  input wire logic hw_unlock_failed,
  input wire logic [CNT_W-1:0] retx_count
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic unl;
  assign unl = hw_unlock_done | hw_unlock_error | hw_unlock_arbl | hw_unlock_failed;

  property p_lock; hw_lock |-> state_o == TXB_READY; endproperty
  a_lock: assert property (p_lock) else $error("lock off ready");
  property p_unl; unl |-> state_o inside {TXB_TX_PROG, TXB_ABORT_PROG}; endproperty
  a_unl: assert property (p_unl) else $error("unlock off transmit");
  property p_avail; available |-> state_o == TXB_READY && !cmd_abort_i; endproperty
  a_avail: assert property (p_avail) else $error("available off ready");
  property p_offer; state_o == TXB_READY && !cmd_abort_i |-> available; endproperty
  a_offer: assert property (p_offer) else $error("ready not offered");
  property p_drop; state_o == TXB_READY && cmd_abort_i |-> !available; endproperty
  a_drop: assert property (p_drop) else $error("abort kept available");
  property p_to_tx; hw_lock && !cmd_abort_i |=> state_o == TXB_TX_PROG; endproperty
  a_to_tx: assert property (p_to_tx) else $error("lock not taken");
  property p_ab_rdy;
    state_o == TXB_READY && cmd_abort_i && !hw_lock |=> state_o == TXB_ABORTED;
  endproperty
  a_ab_rdy: assert property (p_ab_rdy) else $error("abort in ready");
  property p_done; hw_unlock_done |=> state_o == TXB_TX_OK; endproperty
  a_done: assert property (p_done) else $error("done not ok");
  property p_fail; hw_unlock_failed && !hw_unlock_done |=> state_o == TXB_TX_FAILED; endproperty
  a_fail: assert property (p_fail) else $error("failed not taken");
  property p_retry;
    (hw_unlock_error || hw_unlock_arbl) && !hw_unlock_failed && !hw_unlock_done
      && state_o == TXB_TX_PROG && !cmd_abort_i && retx_count != CNT_MAX
      |=> state_o == TXB_READY && retx_count == $past(retx_count) + 4'h1;
  endproperty
  a_retry: assert property (p_retry) else $error("retry wrong");
endmodule

`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import txb_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, wr_en_i = 0, start_i = 0;
  logic cmd_ready_i = 0, cmd_empty_i = 0, cmd_abort_i = 0;
  logic bus_done_i = 0, bus_err_i = 0, bus_arbl_i = 0;
  logic [ADDR_W-1:0] wr_addr_i = '0;
  logic [WORD_W-1:0] wr_data_i = '0, word_o;
  logic [WORD_W-1:0] mem [4];
  logic [2:0] state_o;
  logic locked_o, word_valid_o, busy_o;
  logic [CNT_W-1:0] retx_count_o;
  logic [31:0] seed = 32'h1337;
  int fails = 0, n_compared = 0;

  initial forever #12.5 mclk_i = ~mclk_i;

  txb_link_if txb_link_if_i ();
  txb_device txb_device_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'h1),
    .link(txb_link_if_i.buffer_end), .cmd_ready_i(cmd_ready_i),
    .cmd_empty_i(cmd_empty_i), .cmd_abort_i(cmd_abort_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .state_o(state_o),
    .locked_o(locked_o), .retx_count_o(retx_count_o));
  txb_host txb_host_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'h1),
    .link(txb_link_if_i.control_end), .start_i(start_i), .frame_last_i(5'h03),
    .retx_limit_i(4'h2), .bus_done_i(bus_done_i), .bus_err_i(bus_err_i),
    .bus_arbl_i(bus_arbl_i), .busy_o(busy_o), .word_valid_o(word_valid_o), .word_o(word_o));
  txb_sva txb_sva_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmd_abort_i(cmd_abort_i),
    .state_o(state_o), .available(txb_link_if_i.available),
    .hw_lock(txb_link_if_i.hw_lock), .hw_unlock_done(txb_link_if_i.hw_unlock_done),
    .hw_unlock_error(txb_link_if_i.hw_unlock_error),
    .hw_unlock_arbl(txb_link_if_i.hw_unlock_arbl),
    .hw_unlock_failed(txb_link_if_i.hw_unlock_failed),
    .retx_count(txb_link_if_i.retx_count));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic st(input txb_state_t e, input logic [3:0] c);
    chk("state", 32'(e), 32'(state_o));
    chk("count", 32'(c), 32'(retx_count_o));
  endtask

  // Order: abort empty ready arbl err done
  task automatic pulse(input logic [5:0] v);
    @(posedge mclk_i);
    {cmd_abort_i, cmd_empty_i, cmd_ready_i, bus_arbl_i, bus_err_i, bus_done_i} <= v;
    @(posedge mclk_i);
    {cmd_abort_i, cmd_empty_i, cmd_ready_i, bus_arbl_i, bus_err_i, bus_done_i} <= 6'h00;
    #1;
  endtask

  task automatic fill(input logic upd);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge mclk_i);
      wr_en_i <= 1'h1;
      wr_addr_i <= 5'(i);
      wr_data_i <= seed;
      if (upd) mem[i] = seed;
    end
    @(posedge mclk_i);
    wr_en_i <= 1'h0;
  endtask

  task automatic xmit(input logic [5:0] mid, input logic [5:0] v, input logic keep,
                      input txb_state_t e, input logic [3:0] c);
    int k;
    @(posedge mclk_i);
    start_i <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      k = 0;
      do begin
        @(posedge mclk_i);
        #1;
        k++;
      end while (word_valid_o !== 1'h1 && k < 60);
      chk("word", mem[i], word_o);
    end
    chk("busy", 32'h1, 32'(busy_o));
    @(posedge mclk_i);
    start_i <= keep;
    if (mid != 6'h00) begin
      pulse(mid);
      st(TXB_ABORT_PROG, c);
    end
    pulse(v);
    st(e, c);
    chk("busy", 32'h0, 32'(busy_o));
    $display("test transmit done");
  endtask

  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    results();
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    #1;
    st(TXB_EMPTY, 4'h0);
    chk("locked", 32'h0, 32'(locked_o));
    pulse(6'h20);
    pulse(6'h10);
    st(TXB_EMPTY, 4'h0);
    fill(1'h1);
    pulse(6'h08);
    st(TXB_READY, 4'h0);
    chk("locked", 32'h1, 32'(locked_o));
    fill(1'h0);
    xmit(6'h00, 6'h01, 1'h0, TXB_TX_OK, 4'h0);
    pulse(6'h20);
    st(TXB_TX_OK, 4'h0);
    pulse(6'h10);
    st(TXB_EMPTY, 4'h0);
    $display("test commands done");
    fill(1'h1);
    pulse(6'h08);
    xmit(6'h00, 6'h02, 1'h1, TXB_READY, 4'h1);
    xmit(6'h00, 6'h04, 1'h1, TXB_READY, 4'h2);
    xmit(6'h00, 6'h02, 1'h0, TXB_TX_FAILED, 4'h2);
    pulse(6'h08);
    st(TXB_READY, 4'h0);
    pulse(6'h20);
    st(TXB_ABORTED, 4'h0);
    pulse(6'h08);
    xmit(6'h20, 6'h02, 1'h0, TXB_ABORTED, 4'h0);
    pulse(6'h08);
    xmit(6'h20, 6'h01, 1'h0, TXB_TX_OK, 4'h0);
    pulse(6'h08);
    xmit(6'h00, 6'h21, 1'h0, TXB_TX_OK, 4'h0);
    pulse(6'h08);
    xmit(6'h00, 6'h22, 1'h0, TXB_ABORTED, 4'h0);
    pulse(6'h08);
    xmit(6'h00, 6'h24, 1'h0, TXB_ABORTED, 4'h0);
    results();
  end
endmodule

`default_nettype wire
